/* File: tb/core_fetch_props.sv */
// concurrent checks on the fetch sequencer ports
// assumes binding onto core_fetch_pipeline, a single clock domain
`timescale 1ns/1ps
`include "core_fetch_defs.svh"

module core_fetch_props #(
  parameter int PC_W = 11
) (
  input wire logic            core_clk,
  input wire logic            arst_n,
  input wire logic            rcMode,
  input wire logic            quarter_rate_clock_out,
  input wire logic            oscOutEn,
  input wire logic [3:0]      phaseQ,
  input wire logic [PC_W-1:0] progAddr,
  input wire logic [11:0]     progData,
  input wire logic [11:0]     execInstr,
  input wire logic            execFlushed,
  input wire logic            branchGoto,
  input wire logic            branchCall,
  input wire logic            branchReturn,
  input wire logic [8:0]      branchLiteral,
  input wire logic [4:0]      fileAddr,
  input wire logic [7:0]      fileRdData,
  input wire logic            fileWrEn,
  input wire logic [7:0]      fileWrData,
  input wire logic [7:0]      coreStatus
);
  // ==========================================================================
  // helpers
  logic [PC_W-1:0] pcPlus;
  logic [PC_W-1:0] gotoTgt;
  logic [PC_W-1:0] pclTgt;
  logic            pclWr;
  logic            anyLoad;
  assign pcPlus  = progAddr + 1'b1;
  assign gotoTgt = PC_W'({coreStatus[6:5], branchLiteral});
  assign pclTgt  = PC_W'({coreStatus[6:5], 1'b0, fileWrData});
  assign pclWr   = fileWrEn & (fileAddr == `ADDR_PC_LOW_BYTE);
  assign anyLoad = branchGoto | branchCall | branchReturn | pclWr;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // properties
  sequence s_rest;
    phaseQ == 4'b0010 ##1 phaseQ == 4'b0100 ##1 phaseQ == 4'b1000;
  endsequence
  property p_phase_rotate;
    phaseQ == 4'b0001 |=> s_rest ##1 phaseQ == 4'b0001;
  endproperty
  a_phase_rotate: assert property (p_phase_rotate) else $error("phase order broken");
  property p_phase_onehot;
    $onehot(phaseQ);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
  property p_addr_hold;
    !phaseQ[0] |=> $stable(progAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
  property p_exec_hold;
    !phaseQ[0] |=> $stable(execInstr);
  endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("instruction moved");
  property p_rd_hold;
    !phaseQ[1] |=> $stable(fileRdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_step;
    phaseQ[3] && $past(arst_n) && !anyLoad |-> ##2
      (progAddr == $past(pcPlus, 2) && execInstr == $past(progData, 2) && !execFlushed);
  endproperty
  a_step: assert property (p_step) else $error("sequential fetch wrong");
  property p_goto;
    phaseQ[3] && branchGoto && !branchReturn |-> ##2
      (progAddr == $past(gotoTgt, 2) && execInstr == `NOP_WORD && execFlushed);
  endproperty
  a_goto: assert property (p_goto) else $error("jump load wrong");
  property p_pcl;
    phaseQ[3] && pclWr && !branchGoto && !branchCall && !branchReturn |-> ##2
      (progAddr == $past(pclTgt, 2) && execFlushed);
  endproperty
  a_pcl: assert property (p_pcl) else $error("low byte write load wrong");
  property p_quarter_rate_clock_out;
    rcMode && $past(rcMode) && $past(arst_n) |->
      quarter_rate_clock_out == (phaseQ[2] | phaseQ[3]);
  endproperty
  a_quarter_rate_clock_out: assert property (p_quarter_rate_clock_out) else $error("quarter clock wrong");
  property p_osc_en;
    oscOutEn == rcMode;
  endproperty
  a_osc_en: assert property (p_osc_en) else $error("clock pin enable wrong");
endmodule // core_fetch_props

bind core_fetch_pipeline core_fetch_props #(.PC_W(PC_W)) core_fetch_props_i (.*);

/* File: tb/tb_top.sv */
// self-checking bench for the fetch sequencer, large variant
// assumes core_fetch_props is bound onto the design
`timescale 1ns/1ps
`include "core_fetch_defs.svh"

module tb_top;
  localparam int PW = 11;
  typedef struct packed {logic [PW-1:0] a; logic [11:0] i; logic f;} fetch_t;
  logic core_clk, arst_n, rcMode, quarter_rate_clock_out, oscOutEn, execFlushed;
  logic branchGoto, branchCall, branchReturn, fileWrEn, dirWrEn, optionWrEn;
  logic [3:0] phaseQ, portAPinIn, portEPinIn;
  logic [PW-1:0] progAddr, returnAddr, curAddr, pcNext;
  logic [11:0] progData, execInstr;
  logic [8:0] branchLiteral;
  logic [4:0] fileAddr;
  logic [2:0] dirPortSel;
  logic [7:0] fileRdData, fileWrData, coreStatus, stModel, portBPinIn, portCPinIn, portDPinIn;
  logic [7:0] portBPinOut, portBPinOe;
  logic [5:0] timerPrescaleOptions;
  logic [11:0] mem [2048];
  logic [7:0] rq[$];
  fetch_t fq[$];
  fetch_t fe;
  int error_cnt, samples_checked, cycles, k;

  core_fetch_pipeline #(.VARIANT(core_fetch_pkg::VAR_LARGE)) core_fetch_pipeline_i (.*,
    .portAPinOut(), .portCPinOut(), .portDPinOut(), .portEPinOut(),
    .portAPinOe(), .portCPinOe(), .portDPinOe(), .portEPinOe());

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================================
  // checking
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(negedge core_clk)
  begin
    if (arst_n === 1'b1 && phaseQ === 4'b0010 && fq.size() > 0)
    begin
      fe = fq.pop_front();
      chk("progAddr", fe.a, progAddr);
      chk("execInstr", fe.i, execInstr);
      chk("execFlushed", fe.f, execFlushed);
      chk("pcNext", PW'(fe.a + 1'b1), pcNext);
    end
    if (arst_n === 1'b1 && phaseQ === 4'b0100 && rq.size() > 0)
      chk("fileRdData", rq.pop_front(), fileRdData);
  end

  always @(posedge core_clk)
  begin
    progData <= mem[progAddr];
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================================
  // driving
  task automatic waitQ(input int q);
    int n;
    n = 0;
    @(negedge core_clk);
    while (phaseQ !== 4'(1 << q) && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask

  // br: 0 none, 1 jump, 2 call, 3 return
  task automatic cyc(input logic [4:0] ra, input logic [7:0] re, input logic rd,
                     input logic [4:0] wa, input logic [7:0] wd, input logic wr,
                     input logic [1:0] br, input logic [8:0] lit);
    logic [PW-1:0] tgt;
    logic [PW-1:0] ret;
    logic          ld;
    waitQ(0);
    fileAddr <= ra;
    if (rd)
      rq.push_back(re);
    waitQ(2);
    ret = PW'($urandom);
    ld = (wr && wa == `ADDR_PC_LOW_BYTE) || br != 2'd0;
    tgt = PW'({stModel[6:5], 1'b0, (br == 2'd2) ? lit[7:0] : wd});
    if (br == 2'd1)
      tgt = PW'({stModel[6:5], lit});
    if (br == 2'd3)
      tgt = ret;
    fileWrEn <= wr;
    fileAddr <= wr ? wa : ra;
    fileWrData <= wd;
    branchGoto <= br == 2'd1;
    branchCall <= br == 2'd2;
    branchReturn <= br == 2'd3;
    branchLiteral <= lit;
    returnAddr <= ret;
    if (wr && wa == `ADDR_CORE_STATUS)
      stModel = (stModel & ~`STATUS_WRITE_MASK) | (wd & `STATUS_WRITE_MASK);
    fq.push_back(ld ? {tgt, `NOP_WORD, 1'b1} : {PW'(curAddr + 1'b1), mem[curAddr], 1'b0});
    curAddr = ld ? tgt : PW'(curAddr + 1'b1);
    waitQ(3);
    fileWrEn <= 1'b0;
    {branchGoto, branchCall, branchReturn} <= 3'b000;
  endtask

  initial
  begin
    {arst_n, rcMode, branchGoto, branchCall, branchReturn, fileWrEn, dirWrEn, optionWrEn} = '0;
    {branchLiteral, returnAddr, fileAddr, fileWrData, dirPortSel, progData} = '0;
    {portAPinIn, portBPinIn, portCPinIn, portDPinIn, portEPinIn} = '0;
    void'($urandom(99));
    foreach (mem[i])
      mem[i] = 12'($urandom);
    {portAPinIn, portBPinIn, portCPinIn, portDPinIn, portEPinIn} <= 32'($urandom);
    stModel = `STATUS_RESET;
    repeat (12) @(posedge core_clk);
    chk("progAddr", 32'h7ff, progAddr);
    chk("phaseQ", 32'h8, phaseQ);
    chk("options", `OPTION_RESET, timerPrescaleOptions);
    chk("portBPinOe", 32'h0, portBPinOe);
    chk("coreStatus", `STATUS_RESET, coreStatus);
    arst_n <= 1'b1;
    fq.push_back({11'h7ff, `NOP_WORD, 1'b1});
    curAddr = 11'h7ff;
    cyc(`ADDR_PC_LOW_BYTE, 8'hff, 1, 0, 0, 0, 0, 0);
    cyc(`ADDR_CORE_STATUS, `STATUS_RESET, 1, `ADDR_INDIRECT_PTR, 8'h30, 1, 0, 0);
    cyc(`ADDR_INDIRECT_PTR, 8'h30, 1, `ADDR_INDIRECT_WINDOW, 8'ha5, 1, 0, 0);
    cyc(`ADDR_BANKED_BASE, 8'ha5, 1, `ADDR_INDIRECT_PTR, 8'h50, 1, 0, 0);
    cyc(`ADDR_PORT_A, {4'h0, portAPinIn}, 1, `ADDR_BANKED_BASE, 8'h3c, 1, 0, 0);
    cyc(`ADDR_INDIRECT_WINDOW, 8'h3c, 1, `ADDR_INDIRECT_PTR, 8'h30, 1, 0, 0);
    cyc(`ADDR_BANKED_BASE, 8'ha5, 1, `ADDR_CORE_STATUS, 8'h40, 1, 0, 0);
    cyc(`ADDR_PORT_E, {portEPinIn, 4'h0}, 1, `ADDR_PORT_B, 8'h5a, 1, 0, 0);
    cyc(`ADDR_CORE_STATUS, 8'h58, 1, 0, 0, 0, 2'd1, 9'h123);
    cyc(`ADDR_PORT_D, portDPinIn, 1, 0, 0, 0, 0, 0);
    chk("portBPinOut", 32'h5a, portBPinOut);
    repeat (60)
    begin
      k = $urandom_range(0, 5);
      cyc(`ADDR_PC_LOW_BYTE, curAddr[7:0], 1, `ADDR_PC_LOW_BYTE, 8'($urandom), k == 4,
          (k < 4) ? 2'(k) : 2'd0, 9'($urandom));
      rcMode <= 1'($urandom);
    end
    @(posedge core_clk);
    {dirWrEn, optionWrEn, dirPortSel, fileWrData} <= {2'b11, 3'd1, 8'h0f};
    @(posedge core_clk);
    {dirWrEn, optionWrEn} <= 2'b00;
    repeat (8) @(posedge core_clk);
    chk("portBPinOe", 32'hf0, portBPinOe);
    chk("options", 32'h0f, timerPrescaleOptions);
    chk("fetchQueue", 32'h0, fq.size());
    finish_test();
  end
endmodule // tb_top

/* File: verilog/core_fetch_defs.svh */
// constants for the fetch pipeline and register map
// assumes one oscillator-rate clock and a variant chosen by parameter
`ifndef CORE_FETCH_DEFS_SVH
`define CORE_FETCH_DEFS_SVH

// ==========================================================================
// file addresses
`define ADDR_INDIRECT_WINDOW 5'h00
`define ADDR_TIMER_COUNT     5'h01
`define ADDR_PC_LOW_BYTE     5'h02
`define ADDR_CORE_STATUS     5'h03
`define ADDR_INDIRECT_PTR    5'h04
`define ADDR_PORT_A          5'h05
`define ADDR_PORT_B          5'h06
`define ADDR_PORT_C          5'h07
`define ADDR_PORT_D          5'h08
`define ADDR_PORT_E          5'h09
`define ADDR_BANKED_BASE     5'h10

// ==========================================================================
// special function register counts per variant
`define SFR_COUNT_SMALL 4'h7
`define SFR_COUNT_MID   4'h8
`define SFR_COUNT_LARGE 4'ha

// ==========================================================================
// program counter widths and reset vectors
`define PC_WIDTH_SMALL 9
`define PC_WIDTH_LARGE 11
`define RESET_VECTOR   11'h7ff

// ==========================================================================
// field positions
`define STATUS_PAGE_LO_BIT 5
`define STATUS_PAGE_HI_BIT 6
`define STATUS_WRITE_MASK  8'he7
`define PTR_FORCE_SMALL    8'he0
`define PTR_FORCE_MID      8'h80
`define PTR_FORCE_LARGE    8'h00

// ==========================================================================
// reset values
`define STATUS_RESET    8'h18
`define DIRECTION_RESET 8'hff
`define OPTION_RESET    6'h3f
`define NOP_WORD        12'h000

// ==========================================================================
// timing and general register count
`define PHASES_PER_CYCLE 4
`define GPR_ENTRIES      144

`endif

/* File: verilog/core_fetch_pipeline.sv */
// four-phase fetch/execute sequencer with the core register file
// assumes core_clk is the oscillator input and the execute unit drives
// file accesses and branch requests in step with the phase outputs
// Function
// [RULE_01] oscillator divided by four into four non-overlapping phases per cycle
// [RULE_02] counter increments in phase one, fetched word captured in phase four
// [RULE_03] fetch of next word overlaps execute of current, one cycle each
// [RULE_04] counter-changing instructions take two cycles, prefetched word discarded
// [RULE_05] instruction presented in phase one, executed over phases two to four
// [RULE_06] file operand read in phase two, destination written in phase four
// [RULE_07] smallest variant has a 9-bit counter over 512 twelve-bit words
// [RULE_08] larger variants have an 11-bit counter over 2K twelve-bit words
// [RULE_09] addresses past the implemented store wrap into it
// [RULE_10] reset points the counter at the last program word
// [RULE_11] a non-branching reset-vector instruction wraps execution to address zero
// [RULE_12] larger program stores pick pages from status register bits
// [RULE_13] larger data files pick banks from the indirect pointer
// [RULE_14] file address zero accesses the location the indirect pointer names; a write through it to 02h does not load the counter
// [RULE_15] in RC mode the second oscillator pin outputs a quarter-rate clock
// [RULE_16] address 02h is the counter low byte, reset all ones; upper bits hidden
// [RULE_17] unimplemented bits of narrow port registers read as zero
// [RULE_18] absent port addresses act as general purpose storage
// [RULE_19] smallest variant: 7 special and 25 general registers
// [RULE_20] middle variant: 8 special, 8 unbanked, 64 banked general registers
// [RULE_21] largest variant: 10 special, 6 unbanked, 128 banked general registers
// [RULE_22] status bits 5 and 6 supply counter bits 9 and 10 on loads
// [RULE_23] flush replaces the discarded prefetch with a no-operation
`timescale 1ns/1ps
`include "core_fetch_defs.svh"

module core_fetch_pipeline #(
  parameter core_fetch_pkg::variant_t VARIANT = core_fetch_pkg::VAR_LARGE,
  parameter int                       PC_W    = (VARIANT == core_fetch_pkg::VAR_SMALL) ?
                                                `PC_WIDTH_SMALL : `PC_WIDTH_LARGE
) (
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic            rcMode,
  output logic                 quarter_rate_clock_out,
  output logic                 oscOutEn,
  output logic [3:0]           phaseQ,
  output logic [PC_W-1:0]      progAddr,
  input  wire logic [11:0]     progData,
  output logic [11:0]          execInstr,
  output logic                 execFlushed,
  output logic [PC_W-1:0]      pcNext,
  input  wire logic            branchGoto,
  input  wire logic            branchCall,
  input  wire logic            branchReturn,
  input  wire logic [8:0]      branchLiteral,
  input  wire logic [10:0]     returnAddr,
  input  wire logic [4:0]      fileAddr,
  output logic [7:0]           fileRdData,
  input  wire logic            fileWrEn,
  input  wire logic [7:0]      fileWrData,
  output logic [7:0]           coreStatus,
  input  wire logic            dirWrEn,
  input  wire logic [2:0]      dirPortSel,
  input  wire logic            optionWrEn,
  output logic [5:0]           timerPrescaleOptions,
  input  wire logic [3:0]      portAPinIn,
  input  wire logic [7:0]      portBPinIn,
  input  wire logic [7:0]      portCPinIn,
  input  wire logic [7:0]      portDPinIn,
  input  wire logic [3:0]      portEPinIn,
  output logic [3:0]           portAPinOut,
  output logic [7:0]           portBPinOut,
  output logic [7:0]           portCPinOut,
  output logic [7:0]           portDPinOut,
  output logic [3:0]           portEPinOut,
  output logic [3:0]           portAPinOe,
  output logic [7:0]           portBPinOe,
  output logic [7:0]           portCPinOe,
  output logic [7:0]           portDPinOe,
  output logic [3:0]           portEPinOe
);

  // ========================================================================
  // phase generator
  core_fetch_pkg::phase_t phase_q;
  core_fetch_pkg::phase_t phase_d;
  logic                   quarter_rate_clock_out_q;

  always_comb
  begin
    case (phase_q)
      core_fetch_pkg::PH_Q1: phase_d = core_fetch_pkg::PH_Q2;
      core_fetch_pkg::PH_Q2: phase_d = core_fetch_pkg::PH_Q3;
      core_fetch_pkg::PH_Q3: phase_d = core_fetch_pkg::PH_Q4;
      core_fetch_pkg::PH_Q4: phase_d = core_fetch_pkg::PH_Q1;
      default:               phase_d = core_fetch_pkg::PH_Q1;
    endcase
  end

  wire inQ1 = (phase_q == core_fetch_pkg::PH_Q1);
  wire inQ2 = (phase_q == core_fetch_pkg::PH_Q2);
  wire inQ4 = (phase_q == core_fetch_pkg::PH_Q4);
  wire nextHigh = (phase_d == core_fetch_pkg::PH_Q3) || (phase_d == core_fetch_pkg::PH_Q4);

  assign phaseQ = {inQ4, (phase_q == core_fetch_pkg::PH_Q3), inQ2, inQ1}; // RULE_01

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q  <= core_fetch_pkg::PH_Q4;
      quarter_rate_clock_out_q <= 1'b0;
    end
    else
    begin
      phase_q  <= phase_d; // RULE_01
      quarter_rate_clock_out_q <= rcMode & nextHigh; // RULE_15
    end
  end

  assign quarter_rate_clock_out = quarter_rate_clock_out_q; // RULE_15
  assign oscOutEn               = rcMode; // RULE_15

  // ========================================================================
  // register file address decode
  logic [7:0] status_q;
  logic [7:0] ptr_q;
  logic [7:0] timer_q;

  wire isSmall = (VARIANT == core_fetch_pkg::VAR_SMALL);
  wire isMid   = (VARIANT == core_fetch_pkg::VAR_MID);
  wire [3:0] sfrCount = isSmall ? `SFR_COUNT_SMALL :
                        isMid   ? `SFR_COUNT_MID : `SFR_COUNT_LARGE; // RULE_19 RULE_20 RULE_21
  wire [7:0] ptrForce = isSmall ? `PTR_FORCE_SMALL :
                        isMid   ? `PTR_FORCE_MID : `PTR_FORCE_LARGE;
  wire [7:0] ptrRead  = ptr_q | ptrForce;

  wire       indirect = (fileAddr == `ADDR_INDIRECT_WINDOW); // RULE_14
  wire [4:0] lowAddr  = indirect ? ptrRead[4:0] : fileAddr; // RULE_14
  wire [2:0] bankSel  = isSmall ? 3'h0 : isMid ? {1'b0, ptrRead[6:5]} : ptrRead[7:5]; // RULE_13
  wire       isCommon = (lowAddr < `ADDR_BANKED_BASE);
  wire       sfrHit   = isCommon && (lowAddr[3:0] < sfrCount); // RULE_18
  wire [7:0] gprIdx   = isCommon ? {4'h0, lowAddr[3:0]} :
                        8'({1'b0, bankSel, lowAddr[3:0]} + 8'h10); // RULE_13 RULE_20 RULE_21

  // ========================================================================
  // pin synchronisers, three stages, change taken when last two agree
  localparam int PIN_W = 32;
  logic [PIN_W-1:0] pinS1_q;
  logic [PIN_W-1:0] pinS2_q;
  logic [PIN_W-1:0] pinS3_q;
  logic [PIN_W-1:0] pinStable_q;

  wire [PIN_W-1:0] pinRaw   = {portEPinIn, portDPinIn, portCPinIn, portBPinIn, portAPinIn};
  wire [PIN_W-1:0] pinAgree = ~(pinS2_q ^ pinS3_q);
  wire [PIN_W-1:0] pinNext  = (pinAgree & pinS2_q) | (~pinAgree & pinStable_q);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinS1_q     <= '0;
      pinS2_q     <= '0;
      pinS3_q     <= '0;
      pinStable_q <= '0;
    end
    else
    begin
      pinS1_q     <= pinRaw;
      pinS2_q     <= pinS1_q;
      pinS3_q     <= pinS2_q;
      pinStable_q <= pinNext;
    end
  end

  // ========================================================================
  // port latches and direction control
  logic [7:0] portLat_q [0:4];
  logic [7:0] portDir_q [0:4];
  logic [5:0] option_q;

  wire [7:0] pinA = {4'h0, pinStable_q[3:0]}; // RULE_17
  wire [7:0] pinB = pinStable_q[11:4];
  wire [7:0] pinC = pinStable_q[19:12];
  wire [7:0] pinD = pinStable_q[27:20];
  wire [7:0] pinE = {pinStable_q[31:28], 4'h0}; // RULE_17

  // ========================================================================
  // program counter and pipeline registers
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] fetchAddr_q;
  logic [11:0]     fetchWord_q;
  logic [11:0]     instr_q;
  logic            flush_q;
  logic            flushed_q;
  logic [7:0]      rdData_q;
  logic [7:0]      gpr_q [0:`GPR_ENTRIES-1];

  wire doWrite  = inQ4 && fileWrEn; // RULE_06
  wire pclWrite = doWrite && !indirect && (fileAddr == `ADDR_PC_LOW_BYTE); // RULE_16
  wire [1:0] pageBits = {status_q[`STATUS_PAGE_HI_BIT], status_q[`STATUS_PAGE_LO_BIT]}; // RULE_12

  wire [10:0] tgtGoto = {pageBits, branchLiteral}; // RULE_22
  wire [10:0] tgtLow  = {pageBits, 1'b0, branchCall ? branchLiteral[7:0] : fileWrData}; // RULE_22
  wire [10:0] tgtFull = branchReturn ? returnAddr : branchGoto ? tgtGoto : tgtLow;
  wire        pcLoad  = inQ4 && (branchGoto || branchCall || branchReturn || pclWrite); // RULE_04
  wire [PC_W-1:0] pcTarget = tgtFull[PC_W-1:0]; // RULE_09 RULE_12
  wire [PC_W-1:0] pcInc    = PC_W'(pc_q + 1'b1); // RULE_09 RULE_11

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_q        <= PC_W'(`RESET_VECTOR); // RULE_10
      fetchAddr_q <= PC_W'(`RESET_VECTOR); // RULE_16
      fetchWord_q <= `NOP_WORD;
      instr_q     <= `NOP_WORD;
      flush_q     <= 1'b1;
      flushed_q   <= 1'b1;
    end
    else
    begin
      if (inQ1)
      begin
        fetchAddr_q <= pc_q; // RULE_02 RULE_03
        pc_q        <= pcInc; // RULE_02 RULE_11
        instr_q     <= flush_q ? `NOP_WORD : fetchWord_q; // RULE_05 RULE_23
        flushed_q   <= flush_q; // RULE_23
        flush_q     <= 1'b0;
      end
      else if (pcLoad)
      begin
        pc_q    <= pcTarget; // RULE_04
        flush_q <= 1'b1; // RULE_04
      end
      if (inQ4)
      begin
        fetchWord_q <= progData; // RULE_02
      end
    end
  end

  assign progAddr    = fetchAddr_q; // RULE_07 RULE_08
  assign execInstr   = instr_q;
  assign execFlushed = flushed_q;
  assign pcNext      = pc_q;

  // ========================================================================
  // register file read, phase two
  logic [7:0] sfrRead;

  always_comb
  begin
    case (lowAddr[3:0])
      4'h1:    sfrRead = timer_q;
      4'h2:    sfrRead = fetchAddr_q[7:0]; // RULE_16
      4'h3:    sfrRead = status_q;
      4'h4:    sfrRead = ptrRead;
      4'h5:    sfrRead = pinA; // RULE_17
      4'h6:    sfrRead = pinB;
      4'h7:    sfrRead = pinC;
      4'h8:    sfrRead = pinD;
      4'h9:    sfrRead = pinE; // RULE_17
      default: sfrRead = 8'h00;
    endcase
  end

  wire [7:0] readMux = sfrHit ? sfrRead : gpr_q[gprIdx];

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData_q <= 8'h00;
    end
    else if (inQ2)
    begin
      rdData_q <= readMux; // RULE_06
    end
  end

  assign fileRdData = rdData_q;

  // ========================================================================
  // register file write, phase four
  wire sfrWrite = doWrite && sfrHit;
  wire gprWrite = doWrite && !sfrHit;
  wire [7:0] statusNext = (status_q & ~`STATUS_WRITE_MASK) | (fileWrData & `STATUS_WRITE_MASK);

  always_ff @(posedge core_clk)
  begin
    if (gprWrite)
    begin
      gpr_q[gprIdx] <= fileWrData; // RULE_06 RULE_18
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_q <= `STATUS_RESET;
      ptr_q    <= 8'h00;
      timer_q  <= 8'h00;
    end
    else if (sfrWrite)
    begin
      if (lowAddr == `ADDR_CORE_STATUS)
      begin
        status_q <= statusNext;
      end
      if (lowAddr == `ADDR_INDIRECT_PTR)
      begin
        ptr_q <= fileWrData; // RULE_13
      end
      if (lowAddr == `ADDR_TIMER_COUNT)
      begin
        timer_q <= fileWrData;
      end
    end
  end

  assign coreStatus = status_q;

  // ========================================================================
  // port output latches, direction and option registers
  genvar gp;
  generate
    for (gp = 0; gp < 5; gp++)
    begin : g_port
      wire [3:0] portAddr = 4'(`ADDR_PORT_A + gp);
      wire       latWr    = sfrWrite && (lowAddr[3:0] == portAddr);
      wire       dirWr    = dirWrEn && (dirPortSel == 3'(gp));
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          portLat_q[gp] <= 8'h00;
          portDir_q[gp] <= `DIRECTION_RESET;
        end
        else
        begin
          if (latWr)
          begin
            portLat_q[gp] <= fileWrData;
          end
          if (dirWr)
          begin
            portDir_q[gp] <= fileWrData;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      option_q <= `OPTION_RESET;
    end
    else if (optionWrEn)
    begin
      option_q <= fileWrData[5:0];
    end
  end

  assign timerPrescaleOptions = option_q;

  assign portAPinOut = portLat_q[0][3:0];
  assign portBPinOut = portLat_q[1];
  assign portCPinOut = portLat_q[2];
  assign portDPinOut = portLat_q[3];
  assign portEPinOut = portLat_q[4][7:4];
  assign portAPinOe  = ~portDir_q[0][3:0];
  assign portBPinOe  = ~portDir_q[1];
  assign portCPinOe  = isSmall ? 8'h00 : ~portDir_q[2]; // RULE_18
  assign portDPinOe  = (VARIANT == core_fetch_pkg::VAR_LARGE) ? ~portDir_q[3] : 8'h00; // RULE_18
  assign portEPinOe  = (VARIANT == core_fetch_pkg::VAR_LARGE) ? ~portDir_q[4][7:4] : 4'h0;

endmodule // core_fetch_pipeline

/* File: verilog/core_fetch_pkg.sv */
// types for the fetch pipeline
// assumes core_fetch_defs.svh for the numeric constants
package core_fetch_pkg;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    VAR_SMALL = 2'b00,
    VAR_MID   = 2'b01,
    VAR_LARGE = 2'b10
  } variant_t;

endpackage
